// file: rtl/nvm_pkg.sv
// Purpose: Constants and types for the byte EEPROM access controller
// Assumes: 20 MHz aclk, AXI4-Lite register port, 32-bit data
// Notes: Functional notes follow
// Functional notes
// - Writing one to read strobe with valid address starts a byte read
// - Read finishes in one access; byte lands in data register at once
// - After a read trigger the CPU is stalled for four cycles
// - While writing, reads are ignored and address cannot change
// - Write lasts 26,368 RC oscillator cycles, about 3.3 ms; here 79,104 aclk cycles, about 3.96 ms
// - Registers reachable at data offset and at I/O offset minus 0x20
// - Arm bit self-clears after four cycles; strobe without arm is void
// - Write strobe clears when write time elapses; acts as busy
// - Mode 00 erase+write, 01 erase, 10 write, 11 reserved
// - Ready interrupt asserted while enabled and write strobe clear
package nvm_pkg;
    localparam int ADDR_W = 10;
    localparam int DEPTH = 1024;
    // Register indices (data-space offsets)
    localparam logic [7:0] IDX_CTRL = 8'h3F;
    localparam logic [7:0] IDX_DATA = 8'h40;
    localparam logic [7:0] IDX_ADDR_LO = 8'h41;
    localparam logic [7:0] IDX_ADDR_HI = 8'h42;
    localparam logic [7:0] IO_OFFSET = 8'h20;
    localparam logic [7:0] IO_TOP = 8'h3F;
    // Extra registers: interrupt status, interrupt mask, stall status
    localparam logic [7:0] IDX_IRQ_STAT = 8'h50;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h51;
    localparam logic [7:0] IDX_STATUS = 8'h52;
    localparam int ADDR_BITS = 12;
    // Control bit positions
    localparam int B_READ = 0;
    localparam int B_WRITE = 1;
    localparam int B_ARM = 2;
    localparam int B_RIE = 3;
    localparam int B_PM0 = 4;
    // Interrupt status bits
    localparam int S_READ_DONE = 0;
    localparam int S_WRITE_DONE = 1;
    localparam logic [1:0] IRQ_ALL = 2'h3;
    // Timing
    localparam int ARM_CYCLES = 4;
    localparam int STALL_CYCLES = 4;
    localparam int WRITE_OSC_CYCLES = 26368;
    localparam real WRITE_TIME_MS = 3.3;
    localparam real CLK_MHZ = 20.0;
    // RC oscillator rate derived from its cycle count and typical time
    localparam real OSC_KHZ = WRITE_OSC_CYCLES / WRITE_TIME_MS;
    localparam int OSC_DIV = int'(CLK_MHZ * 1000.0 / OSC_KHZ);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        PM_ERASE_WRITE = 2'h0,
        PM_ERASE_ONLY = 2'h1,
        PM_WRITE_ONLY = 2'h2,
        PM_RESERVED = 2'h3
    } pmode_t;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        pmode_t mode;
        logic start;
    } wr_req_t;
    function automatic logic [7:0] to_index(input logic [ADDR_BITS-1:0] a);
        logic [7:0] idx;
        idx = a[9:2];
        // Short I/O window maps back onto the data-space offsets
        if (a[ADDR_BITS-1:10] == 2'h1) begin
            idx = a[9:2] + IO_OFFSET;
        end
        return idx;
    endfunction
endpackage

// file: rtl/nvm_cell_array.sv
// Purpose: Byte array with write sequencer timed from the RC oscillator
// Assumes: One write at a time, requested by the controller
// Notes: Erase sets a byte to all ones
`timescale 1ns/1ps
module nvm_cell_array (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic osc_tick,
    input wire nvm_pkg::wr_req_t req,
    input wire logic [nvm_pkg::ADDR_W-1:0] raddr,
    output logic [7:0] rdata,
    output logic done
);
    import nvm_pkg::*;
    typedef enum logic {IDLE, BUSY} wst_t;
    typedef struct packed {
        wst_t st;
        logic [14:0] cnt;
        logic done;
        wr_req_t held;
    } cst_t;
    cst_t s_ff, nxt_s;
    logic [7:0] mem [DEPTH];
    logic [7:0] new_byte;
    logic commit;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        commit = 1'b0;
        case (s_ff.st)
            IDLE: begin
                if (req.start) begin
                    nxt_s.st = BUSY;
                    nxt_s.held = req;
                    nxt_s.cnt = '0;
                end
            end
            BUSY: begin
                if (osc_tick) begin
                    nxt_s.cnt = s_ff.cnt + 15'h1;
                    if (s_ff.cnt == 15'(WRITE_OSC_CYCLES - 1)) begin
                        nxt_s.st = IDLE;
                        nxt_s.done = 1'b1;
                        commit = 1'b1;
                    end
                end
            end
            default: nxt_s.st = IDLE;
        endcase
    end

    // Programming mode decides the stored result
    always_comb begin
        case (s_ff.held.mode)
            PM_ERASE_WRITE: new_byte = s_ff.held.wdata;
            PM_ERASE_ONLY: new_byte = 8'hFF;
            PM_WRITE_ONLY: new_byte = mem[s_ff.held.addr] & s_ff.held.wdata;
            default: new_byte = mem[s_ff.held.addr];
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Array content is not reset, like real cells
    always_ff @(posedge aclk) begin
        if (commit) begin
            mem[s_ff.held.addr] <= new_byte;
        end
    end

    assign rdata = mem[raddr];
    assign done = s_ff.done;
endmodule

// file: rtl/nvm_byte_ctrl.sv
// Purpose: AXI4-Lite register front end for byte EEPROM access
// Assumes: Single clock; CPU stall shown as cpu_stall output
// Notes: Registers sit at four times their index
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module nvm_byte_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [nvm_pkg::ADDR_BITS-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [nvm_pkg::ADDR_BITS-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic global_irq_en,
    output logic cpu_stall,
    output logic ready_irq,
    output logic irq
);
    import nvm_pkg::*;
    typedef struct packed {
        logic [ADDR_BITS-1:0] awaddr;
        logic aw_have;
        logic [31:0] wdata;
        logic w_have;
        logic lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
        logic [1:0] pm;
        logic rie;
        logic arm;
        logic [2:0] arm_cnt;
        logic wbusy;
        logic [2:0] stall_cnt;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [15:0] div;
    } st_t;
    st_t s_ff, nxt_s;
    wr_req_t wreq;
    logic [7:0] arr_q;
    logic wr_done;
    logic osc_tick;
    logic wr_go;
    logic [7:0] widx;
    logic [7:0] ridx;
    logic [7:0] wb;
    logic [7:0] ctrl_rd;
    logic [1:0] ev;

    nvm_cell_array u_cells (
        .aclk(aclk),
        .aresetn(aresetn),
        .osc_tick(osc_tick),
        .req(wreq),
        .raddr(s_ff.addr),
        .rdata(arr_q),
        .done(wr_done)
    );

    assign osc_tick = (s_ff.div == 16'(OSC_DIV - 1));
    assign widx = to_index(s_ff.awaddr);
    assign ridx = to_index(s_axi_araddr);
    assign wb = s_ff.wdata[7:0];
    assign wr_go = s_ff.aw_have && s_ff.w_have && !s_ff.bvalid;
    // Read strobe always reads zero
    assign ctrl_rd = {2'h0, s_ff.pm, s_ff.rie, s_ff.arm, s_ff.wbusy, 1'b0};

    always_comb begin
        nxt_s = s_ff;
        ev = 2'h0;
        // Request payload follows the live registers; start is a pulse
        wreq.addr = s_ff.addr;
        wreq.wdata = s_ff.data;
        wreq.mode = pmode_t'(s_ff.pm);
        wreq.start = 1'b0;
        nxt_s.div = osc_tick ? 16'h0 : s_ff.div + 16'h1;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_s.awaddr = s_axi_awaddr;
            nxt_s.aw_have = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_s.wdata = s_axi_wdata;
            nxt_s.lane0 = s_axi_wstrb[0];
            nxt_s.w_have = 1'b1;
        end
        if (s_ff.arm) begin
            nxt_s.arm_cnt = s_ff.arm_cnt + 3'h1;
            if (s_ff.arm_cnt == 3'(ARM_CYCLES - 1)) begin
                nxt_s.arm = 1'b0;
            end
        end
        if (s_ff.stall_cnt != 3'h0) begin
            nxt_s.stall_cnt = s_ff.stall_cnt - 3'h1;
        end
        if (wr_done) begin
            nxt_s.wbusy = 1'b0;
            ev[S_WRITE_DONE] = 1'b1;
        end
        if (wr_go) begin
            nxt_s.aw_have = 1'b0;
            nxt_s.w_have = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = RESP_OKAY;
            // Byte lane 0 strobe gates every register update
            case (widx)
                IDX_CTRL: if (s_ff.lane0) begin
                    if (!s_ff.wbusy) begin
                        nxt_s.pm = wb[B_PM0+1:B_PM0];
                    end
                    nxt_s.rie = wb[B_RIE];
                    if (wb[B_ARM] && !wb[B_WRITE]) begin
                        nxt_s.arm = 1'b1;
                        nxt_s.arm_cnt = 3'h0;
                    end
                    // Write start needs a live arm bit
                    if (wb[B_WRITE] && s_ff.arm && !s_ff.wbusy) begin
                        nxt_s.wbusy = 1'b1;
                        nxt_s.arm = 1'b0;
                        wreq.start = 1'b1;
                    end else if (wb[B_READ] && !s_ff.wbusy) begin
                        nxt_s.data = arr_q;
                        nxt_s.stall_cnt = 3'(STALL_CYCLES);
                        ev[S_READ_DONE] = 1'b1;
                    end
                end
                IDX_DATA: if (s_ff.lane0) nxt_s.data = wb;
                IDX_ADDR_LO: if (s_ff.lane0 && !s_ff.wbusy) begin
                    nxt_s.addr[7:0] = wb;
                end
                IDX_ADDR_HI: if (s_ff.lane0 && !s_ff.wbusy) begin
                    nxt_s.addr[ADDR_W-1:8] = wb[ADDR_W-9:0];
                end
                IDX_IRQ_STAT: if (s_ff.lane0) begin
                    nxt_s.irq_stat = s_ff.irq_stat & ~wb[1:0];
                end
                IDX_IRQ_MASK: if (s_ff.lane0) nxt_s.irq_mask = wb[1:0];
                default: nxt_s.bresp = RESP_SLVERR;
            endcase
        end
        // Set wins over write-one-to-clear
        nxt_s.irq_stat = nxt_s.irq_stat | ev;
        if (s_axi_bvalid && s_axi_bready) begin
            nxt_s.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp = RESP_OKAY;
            nxt_s.rdata = 32'h0000_0000;
            case (ridx)
                IDX_CTRL: nxt_s.rdata[7:0] = ctrl_rd;
                IDX_DATA: nxt_s.rdata[7:0] = s_ff.data;
                IDX_ADDR_LO: nxt_s.rdata[7:0] = s_ff.addr[7:0];
                IDX_ADDR_HI: nxt_s.rdata[1:0] = s_ff.addr[ADDR_W-1:8];
                IDX_IRQ_STAT: nxt_s.rdata[1:0] = s_ff.irq_stat;
                IDX_IRQ_MASK: nxt_s.rdata[1:0] = s_ff.irq_mask;
                IDX_STATUS: nxt_s.rdata[0] = s_ff.stall_cnt != 3'h0;
                default: nxt_s.rresp = RESP_SLVERR;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            nxt_s.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Stall and in-flight capture: one of each at a time
    assign s_axi_awready = !s_ff.aw_have && !s_ff.bvalid;
    assign s_axi_wready = !s_ff.w_have && !s_ff.bvalid;
    assign s_axi_bvalid = s_ff.bvalid;
    assign s_axi_bresp = s_ff.bresp;
    assign s_axi_arready = !s_ff.rvalid;
    assign s_axi_rvalid = s_ff.rvalid;
    assign s_axi_rdata = s_ff.rdata;
    assign s_axi_rresp = s_ff.rresp;
    assign cpu_stall = s_ff.stall_cnt != 3'h0;
    assign ready_irq = s_ff.rie && global_irq_en && !s_ff.wbusy;
    assign irq = |(s_ff.irq_stat & s_ff.irq_mask);

    a_arm_timeout: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(s_ff.arm) |-> s_ff.arm[*3] ##2 !s_ff.arm)
        else $error("arm bit did not clear after four cycles");
    a_stall_len: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(cpu_stall) |-> cpu_stall[*4] ##1 !cpu_stall)
        else $error("stall not four cycles");
    a_addr_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_ff.wbusy && $past(s_ff.wbusy) |-> $stable(s_ff.addr))
        else $error("address changed during write");
    a_busy_done: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_done |=> !s_ff.wbusy)
        else $error("write strobe not cleared at done");
    a_read_data: assert property (@(posedge aclk) disable iff (!aresetn)
        ev[S_READ_DONE] |=> s_ff.data == $past(arr_q))
        else $error("read data not captured");
    a_no_read_busy: assert property (@(posedge aclk) disable iff (!aresetn)
        s_ff.wbusy |-> !ev[S_READ_DONE])
        else $error("read taken during write");
    a_data_keep: assert property (@(posedge aclk) disable iff (!aresetn)
        wreq.start |=> s_ff.data == $past(s_ff.data))
        else $error("data register changed by write");
    a_ready_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        s_ff.wbusy |-> !ready_irq)
        else $error("ready interrupt during write");
    a_strobe_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && ridx == IDX_CTRL
        |=> !s_axi_rdata[B_READ])
        else $error("read strobe reads one");
    c_read: cover property (@(posedge aclk) ev[S_READ_DONE]);
    c_write: cover property (@(posedge aclk) wreq.start);
    c_wdone: cover property (@(posedge aclk) wr_done);
    c_irq: cover property (@(posedge aclk) irq);
endmodule

// file: sim/cpu_model.sv
// Purpose: CPU side register bus master for the byte access controller
// Assumes: AXI4-Lite, one write and one read under way at most
// Notes: Handshakes seen at the falling edge, acted on at the next rise
`timescale 1ns/1ps
module cpu_model (
    input wire logic aclk,
    output logic [nvm_pkg::ADDR_BITS-1:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [nvm_pkg::ADDR_BITS-1:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    import nvm_pkg::*;
    initial begin
        awaddr = '0;
        awvalid = 1'b0;
        wdata = '0;
        wstrb = 4'hf;
        wvalid = 1'b0;
        araddr = '0;
        arvalid = 1'b0;
        // Always ready for answers, so no release race on these
        bready = 1'b1;
        rready = 1'b1;
    end
    // Called at a rising edge; returns at the edge that takes the answer
    task automatic wr(input logic [ADDR_BITS-1:0] a, input logic [31:0] d,
        output logic [1:0] r);
        logic fa, fw, fb;
        fb = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!fb) begin
            @(negedge aclk);
            fa = awvalid && awready;
            fw = wvalid && wready;
            fb = bvalid;
            r = bresp;
            @(posedge aclk);
            if (fa) awvalid <= 1'b0;
            if (fw) wvalid <= 1'b0;
        end
    endtask
    task automatic rd(input logic [ADDR_BITS-1:0] a, output logic [31:0] d,
        output logic [1:0] r);
        logic fa, fr;
        fr = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!fr) begin
            @(negedge aclk);
            fa = arvalid && arready;
            fr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (fa) arvalid <= 1'b0;
        end
    endtask
endmodule

// file: sim/eeprom_byte_access_control_bench.sv
// Purpose: Self-checking bench for the byte access controller
// Assumes: One full write only; it costs about 79k clocks
// Notes: Register writes carry all byte strobes; lane 0 gates them
`timescale 1ns/1ps
module eeprom_byte_access_control_bench;
    import nvm_pkg::*;
    localparam logic [ADDR_BITS-1:0] A_CTRL = 12'h0fc;
    localparam logic [ADDR_BITS-1:0] A_DATA = 12'h100;
    localparam logic [ADDR_BITS-1:0] A_LO = 12'h104;
    localparam logic [ADDR_BITS-1:0] A_HI = 12'h108;
    localparam logic [ADDR_BITS-1:0] A_LO_IO = 12'h484;
    localparam logic [ADDR_BITS-1:0] A_DATA_IO = 12'h480;
    localparam logic [ADDR_BITS-1:0] A_STAT = 12'h140;
    localparam logic [ADDR_BITS-1:0] A_MASK = 12'h144;
    localparam logic [ADDR_BITS-1:0] A_STS = 12'h148;
    localparam logic [ADDR_BITS-1:0] A_BAD = 12'h200;
    logic aclk, aresetn, global_irq_en, cpu_stall, ready_irq, irq;
    logic [ADDR_BITS-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int n_errors = 0;
    int n_compared = 0;
    int stall_cnt = 0;
    nvm_byte_ctrl nvm_byte_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .global_irq_en(global_irq_en), .cpu_stall(cpu_stall),
        .ready_irq(ready_irq), .irq(irq));
    cpu_model cpu_model_inst (.aclk(aclk), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready));
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (cpu_stall === 1'b1) stall_cnt <= stall_cnt + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        n_compared++;
        if (got !== e) begin
            n_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask
    task automatic w(input logic [ADDR_BITS-1:0] a, input logic [31:0] d);
        logic [1:0] r;
        cpu_model_inst.wr(a, d, r);
        chk(32'(r), 32'(RESP_OKAY));
    endtask
    task automatic rc(input logic [ADDR_BITS-1:0] a, input logic [31:0] m,
        input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        cpu_model_inst.rd(a, d, r);
        chk(d & m, e);
    endtask
    // Pins settle well away from any edge before they are judged
    task automatic pins(input logic [2:0] e);
        repeat (8) @(posedge aclk);
        @(negedge aclk);
        chk(32'({cpu_stall, ready_irq, irq}), 32'(e));
        @(posedge aclk);
    endtask
    task automatic t_reset;
        pins(3'b000);
        rc(A_CTRL, 32'h0000_000f, 32'h0000_0000);
    endtask
    task automatic t_bad;
        logic [31:0] d;
        logic [1:0] r;
        cpu_model_inst.wr(A_BAD, 32'h0000_0001, r);
        chk(32'(r), 32'(RESP_SLVERR));
        cpu_model_inst.rd(A_BAD, d, r);
        chk(32'(r), 32'(RESP_SLVERR));
    endtask
    task automatic t_alias;
        w(A_LO_IO, 32'h0000_0012);
        w(A_HI, 32'h0000_0001);
        w(A_DATA, 32'h0000_005a);
        rc(A_LO, 32'h0000_00ff, 32'h0000_0012);
        rc(A_HI, 32'h0000_0003, 32'h0000_0001);
        rc(A_DATA_IO, 32'h0000_00ff, 32'h0000_005a);
    endtask
    task automatic t_noarm;
        w(A_CTRL, 32'h0000_0002);
        rc(A_CTRL, 32'h0000_0002, 32'h0000_0000);
    endtask
    task automatic t_write;
        time t0;
        int n, n0, cyc, ex;
        logic [31:0] d;
        logic [1:0] r;
        global_irq_en <= 1'b1;
        w(A_CTRL, 32'h0000_000c);
        w(A_CTRL, 32'h0000_000a);
        t0 = $time;
        rc(A_CTRL, 32'h0000_0002, 32'h0000_0002);
        pins(3'b000);
        w(A_LO, 32'h0000_0034);
        rc(A_LO, 32'h0000_00ff, 32'h0000_0012);
        n0 = stall_cnt;
        w(A_CTRL, 32'h0000_001b);
        rc(A_CTRL, 32'h0000_0031, 32'h0000_0000);
        rc(A_DATA, 32'h0000_00ff, 32'h0000_005a);
        pins(3'b000);
        chk(32'(stall_cnt - n0), 32'h0000_0000);
        // Poll step is a few clocks, hence the tolerance on the span
        for (n = 0; n < 40000; n++) begin
            cpu_model_inst.rd(A_CTRL, d, r);
            if (d[B_WRITE] === 1'b0) break;
        end
        cyc = int'(($time - t0) / 50);
        ex = WRITE_OSC_CYCLES * OSC_DIV;
        chk(32'(cyc > ex - 12 && cyc < ex + 12), 32'h0000_0001);
        pins(3'b010);
        rc(A_DATA, 32'h0000_00ff, 32'h0000_005a);
        rc(A_STAT, 32'h0000_0002, 32'h0000_0002);
    endtask
    task automatic t_irq;
        w(A_MASK, 32'h0000_0003);
        pins(3'b011);
        w(A_MASK, 32'h0000_0000);
        pins(3'b010);
        w(A_STAT, 32'h0000_0002);
        w(A_MASK, 32'h0000_0003);
        pins(3'b010);
        global_irq_en <= 1'b0;
        pins(3'b000);
        global_irq_en <= 1'b1;
    endtask
    task automatic t_read;
        int n0;
        w(A_DATA, 32'h0000_00c3);
        n0 = stall_cnt;
        w(A_CTRL, 32'h0000_0009);
        rc(A_STS, 32'h0000_0001, 32'h0000_0001);
        rc(A_DATA, 32'h0000_00ff, 32'h0000_005a);
        pins(3'b011);
        chk(32'(stall_cnt - n0), 32'(STALL_CYCLES));
        rc(A_CTRL, 32'h0000_0001, 32'h0000_0000);
        rc(A_STAT, 32'h0000_0001, 32'h0000_0001);
    endtask
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Budget well above the single write plus the short scenarios
    initial begin
        #(50 * 100000);
        n_errors++;
        wrap_up;
    end
    initial begin
        aresetn = 1'b0;
        global_irq_en = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_bad;
        t_alias;
        t_noarm;
        t_write;
        t_irq;
        t_read;
        wrap_up;
    end
endmodule
